// file: charger_host_model.sv
// register host model that issues word writes to the block
`timescale 1ns/10ps
`default_nettype none
module charger_host_model
    import charger_mode_pkg::*;
(
    input wire logic clk,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [15:0] wr_data
);
    // idle bus shows a moving pattern so stale data is never trusted
    logic [15:0] junk;
    initial begin
        junk = 16'hA5C3;
        wr_en = 1'b0;
        wr_addr = 8'hFF;
        wr_data = junk;
    end
    // one word per strobe, raised and dropped on falling edges
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
        junk = ~d;
        wr_data = junk;
        wr_addr = ~a;
    endtask : wr
    // setpoint rewrite keeps charging alive or restarts it
    task automatic kick(input logic [15:0] v);
        wr(UPPER_RAIL_ADDR, v);
    endtask : kick
endmodule : charger_host_model
`default_nettype wire

// file: charger_mode_control.sv
// turbo gate, two-level limit, charge mode and watchdog control
//
// Contract
// - enter input power limiting on adapter limit or input voltage reference
// - in turbo, gate on when system rail drops below battery by margin
// - leave turbo on charge current, or low discharge beyond exit time
// - exit time 40ms or 80ms chosen by option bit 8
// - gate follows charge current and turbo enable truth table
// - near first limit, cycle second limit for t2 then first for t1
// - either limit may be the larger; each applied as written
// - limiter enable bit; disabled means first limit only
// - current monitor enable and source from config bits, direction from option bit 3
// - power monitor gain select from option bit 9
// - power monitor enable; held off on battery below 5.2V
// - trickle only with nonzero charge current and battery below minimum
// - trickle current code from bits 15:14
// - battery above minimum moves to fast charge at programmed limit
// - no battery or gate off regulates rail to upper setpoint
// - no kick write within watchdog period turns gate off
// - watchdog period from option bits 12:11
// - expiry keeps charge current; write of kick registers resumes
// - watchdog fully disabled by primary option bit 7
`timescale 1ns/10ps
`default_nettype none
module charger_mode_control
    import charger_mode_pkg::*;
#(
    parameter longint EXIT_SHORT_CYC = TURBO_EXIT_SHORT_CYC,
    parameter longint EXIT_LONG_CYC =
        EXIT_SHORT_CYC * TURBO_EXIT_LONG_MS / TURBO_EXIT_SHORT_MS,
    parameter longint WDT0_CYC = WDT_BASE_CYC,
    parameter longint WDT1_CYC = 2 * WDT0_CYC,
    parameter longint WDT2_CYC = 4 * WDT0_CYC,
    parameter longint WDT3_CYC = 8 * WDT0_CYC,
    parameter longint T1_CYC = 1_250_000,
    parameter longint T2_CYC = 125_000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [7:0] rd_addr,
    output logic [15:0] rd_data,
    input wire logic [IN_COUNT-1:0] comp_raw,
    output logic battery_switch_gate,
    output logic input_power_limit,
    output logic vin_ref_select,
    output logic [15:0] active_adapter_limit,
    output logic trickle_charge,
    output logic fast_charge,
    output logic [1:0] trickle_current_code,
    output logic regulate_upper_rail,
    output logic monitor_enable,
    output logic monitor_battery_select,
    output logic monitor_direction,
    output logic platform_power_monitor_enable,
    output logic platform_power_gain_low
);
    localparam int CW = 40;

    // elaboration checks
    if (T1_CYC < 1 || T2_CYC < 1 || EXIT_SHORT_CYC < 1 ||
        EXIT_LONG_CYC < 1 || WDT0_CYC < 1) begin : g_bad_timing
        $error("timing parameters must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change taken when two and three agree
    logic [IN_COUNT-1:0] s1;
    logic [IN_COUNT-1:0] s2;
    logic [IN_COUNT-1:0] s3;
    logic [IN_COUNT-1:0] cin;
    for (genvar i = 0; i < IN_COUNT; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                s1[i] <= 1'b0;
                s2[i] <= 1'b0;
                s3[i] <= 1'b0;
                cin[i] <= 1'b0;
            end else begin
                s1[i] <= comp_raw[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    cin[i] <= s3[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [15:0] primary_option_reg;
    logic [15:0] secondary_config_reg;
    logic [15:0] tertiary_config_reg;
    logic [15:0] quaternary_option_reg;
    logic [15:0] charge_current_setting;
    logic [15:0] upper_rail_setpoint;
    logic [15:0] adapter_limit_first;
    logic [15:0] adapter_limit_second;
    logic kick;
    assign kick = wr_en && (wr_addr == CHARGE_CURRENT_ADDR ||
                            wr_addr == UPPER_RAIL_ADDR);

    // writes land one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            primary_option_reg <= OPTION_RESET;
            secondary_config_reg <= OPTION_RESET;
            tertiary_config_reg <= OPTION_RESET;
            quaternary_option_reg <= OPTION_RESET;
            charge_current_setting <= SETTING_RESET;
            upper_rail_setpoint <= SETTING_RESET;
            adapter_limit_first <= SETTING_RESET;
            adapter_limit_second <= SETTING_RESET;
        end else if (wr_en) begin
            case (wr_addr)
                PRIMARY_OPTION_ADDR: primary_option_reg <= wr_data;
                SECONDARY_CONFIG_ADDR: secondary_config_reg <= wr_data;
                TERTIARY_CONFIG_ADDR: tertiary_config_reg <= wr_data;
                QUATERNARY_OPTION_ADDR: quaternary_option_reg <= wr_data;
                CHARGE_CURRENT_ADDR: charge_current_setting <= wr_data;
                UPPER_RAIL_ADDR: upper_rail_setpoint <= wr_data;
                ADAPTER_FIRST_ADDR: adapter_limit_first <= wr_data;
                ADAPTER_SECOND_ADDR: adapter_limit_second <= wr_data;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // turbo detection and exit timer
    logic turbo_enabled;
    logic turbo_active;
    logic [CW-1:0] exit_cnt;
    logic [CW-1:0] exit_limit;
    assign turbo_enabled = !primary_option_reg[TURBO_DIS_BIT];
    assign exit_limit = quaternary_option_reg[EXIT_SEL_BIT] ?
        CW'(EXIT_LONG_CYC) : CW'(EXIT_SHORT_CYC);

    // low discharge must persist for the whole exit time
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            turbo_active <= 1'b0;
            exit_cnt <= '0;
        end else if (!turbo_active) begin
            exit_cnt <= '0;
            if (turbo_enabled && cin[IN_SYS_BELOW_BAT]) begin
                turbo_active <= 1'b1;
            end
        end else if (!turbo_enabled || cin[IN_CHG_150MA]) begin
            turbo_active <= 1'b0;
            exit_cnt <= '0;
        end else if (cin[IN_DSG_BELOW_200MA]) begin
            if (exit_cnt >= exit_limit - CW'(1)) begin
                turbo_active <= 1'b0;
                exit_cnt <= '0;
            end else begin
                exit_cnt <= exit_cnt + CW'(1);
            end
        end else begin
            exit_cnt <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-level adapter limiter
    limit_phase_t phase;
    logic [CW-1:0] phase_cnt;
    logic two_level_on;
    assign two_level_on = tertiary_config_reg[TWO_LEVEL_BIT];

    // the pattern repeats until the adapter backs off at the end of t1
    always_ff @(posedge clk) begin
        if (!rst_b || !two_level_on) begin
            phase <= LIM_IDLE;
            phase_cnt <= '0;
        end else begin
            case (phase)
                LIM_IDLE: begin
                    phase_cnt <= '0;
                    if (cin[IN_ADP_NEAR_FIRST]) begin
                        phase <= LIM_SECOND;
                    end
                end
                LIM_SECOND: begin
                    if (phase_cnt >= CW'(T2_CYC) - CW'(1)) begin
                        phase <= LIM_FIRST;
                        phase_cnt <= '0;
                    end else begin
                        phase_cnt <= phase_cnt + CW'(1);
                    end
                end
                LIM_FIRST: begin
                    if (phase_cnt >= CW'(T1_CYC) - CW'(1)) begin
                        phase <= cin[IN_ADP_NEAR_FIRST] ? LIM_SECOND : LIM_IDLE;
                        phase_cnt <= '0;
                    end else begin
                        phase_cnt <= phase_cnt + CW'(1);
                    end
                end
                default: begin
                    phase <= LIM_IDLE;
                    phase_cnt <= '0;
                end
            endcase
        end
    end

    // each limit applied as written, no ordering assumed
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            active_adapter_limit <= SETTING_RESET;
        end else if (phase == LIM_SECOND) begin
            active_adapter_limit <= adapter_limit_second;
        end else begin
            active_adapter_limit <= adapter_limit_first;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // charge watchdog
    logic [CW-1:0] wdt_cnt;
    logic [CW-1:0] wdt_limit;
    logic wdt_expired;
    logic wdt_hit;
    always_comb begin
        case (quaternary_option_reg[WDT_SEL_LSB +: 2])
            2'h0: wdt_limit = CW'(WDT0_CYC);
            2'h1: wdt_limit = CW'(WDT1_CYC);
            2'h2: wdt_limit = CW'(WDT2_CYC);
            default: wdt_limit = CW'(WDT3_CYC);
        endcase
    end
    assign wdt_hit = !primary_option_reg[WDT_DIS_BIT] &&
        wdt_cnt >= wdt_limit - CW'(1);

    // expiry wins over a kick in the same cycle; setting stays untouched
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdt_cnt <= '0;
            wdt_expired <= 1'b0;
        end else if (primary_option_reg[WDT_DIS_BIT]) begin
            wdt_cnt <= '0;
            wdt_expired <= 1'b0;
        end else begin
            wdt_cnt <= (kick || wdt_hit) ? '0 : wdt_cnt + CW'(1);
            if (wdt_hit) begin
                wdt_expired <= 1'b1;
            end else if (kick) begin
                wdt_expired <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gate, charge mode, regulation and monitor outputs
    logic chg_nonzero;
    logic next_gate;
    assign chg_nonzero = charge_current_setting != SETTING_RESET;
    assign next_gate = !wdt_expired &&
        (chg_nonzero || (turbo_enabled && turbo_active));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            battery_switch_gate <= 1'b0;
            trickle_charge <= 1'b0;
            fast_charge <= 1'b0;
            regulate_upper_rail <= 1'b1;
            input_power_limit <= 1'b0;
        end else begin
            battery_switch_gate <= next_gate;
            trickle_charge <= next_gate && chg_nonzero &&
                cin[IN_BAT_BELOW_MIN];
            fast_charge <= next_gate && chg_nonzero &&
                !cin[IN_BAT_BELOW_MIN];
            regulate_upper_rail <= !cin[IN_BAT_PRESENT] || !next_gate;
            input_power_limit <= cin[IN_ADP_AT_LIMIT] ||
                cin[IN_VIN_AT_REF];
        end
    end

    // monitor settings are register bits, platform_power_monitor gated by battery level
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vin_ref_select <= 1'b0;
            trickle_current_code <= 2'h0;
            monitor_enable <= 1'b0;
            monitor_battery_select <= 1'b0;
            monitor_direction <= 1'b0;
            platform_power_monitor_enable <= 1'b0;
            platform_power_gain_low <= 1'b0;
        end else begin
            vin_ref_select <= primary_option_reg[VIN_REF_BIT];
            trickle_current_code <=
                tertiary_config_reg[TRICKLE_LSB +: 2];
            monitor_enable <= secondary_config_reg[MON_EN_BIT];
            monitor_battery_select <= secondary_config_reg[MON_SEL_BIT];
            monitor_direction <= quaternary_option_reg[MON_DIR_BIT];
            platform_power_monitor_enable <=
                secondary_config_reg[PLATFORM_POWER_MONITOR_EN_BIT] &&
                !(cin[IN_BATTERY_ONLY] && !cin[IN_BAT_ABOVE_5V2]);
            platform_power_gain_low <=
                quaternary_option_reg[PLATFORM_POWER_MONITOR_GAIN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, one cycle latency, unmapped reads as zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else begin
            case (rd_addr)
                PRIMARY_OPTION_ADDR: rd_data <= primary_option_reg;
                SECONDARY_CONFIG_ADDR: rd_data <= secondary_config_reg;
                TERTIARY_CONFIG_ADDR: rd_data <= tertiary_config_reg;
                QUATERNARY_OPTION_ADDR: rd_data <= quaternary_option_reg;
                CHARGE_CURRENT_ADDR: rd_data <= charge_current_setting;
                UPPER_RAIL_ADDR: rd_data <= upper_rail_setpoint;
                ADAPTER_FIRST_ADDR: rd_data <= adapter_limit_first;
                ADAPTER_SECOND_ADDR: rd_data <= adapter_limit_second;
                MODE_STATUS_ADDR: rd_data <= {10'h000, phase, trickle_charge,
                    battery_switch_gate, wdt_expired, turbo_active};
                default: rd_data <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence second_done_s;
        phase == LIM_SECOND ##1 phase == LIM_FIRST;
    endsequence

    limit_power_a: assert property (cin[IN_VIN_AT_REF] |=> input_power_limit)
        else $error("input limit missed");
    turbo_entry_a: assert property (!turbo_active && turbo_enabled &&
        cin[IN_SYS_BELOW_BAT] |=> turbo_active)
        else $error("turbo not entered");
    turbo_exit_a: assert property (turbo_active && cin[IN_CHG_150MA]
        |=> !turbo_active)
        else $error("turbo not left on charge current");
    gate_truth_a: assert property (chg_nonzero && !wdt_expired
        |=> battery_switch_gate)
        else $error("gate off with charge current set");
    limit_phase_a: assert property (second_done_s |->
        active_adapter_limit == $past(adapter_limit_second))
        else $error("second limit not applied");
    limit_single_a: assert property (!two_level_on ##1 !two_level_on
        |=> active_adapter_limit == $past(adapter_limit_first))
        else $error("first limit not used");
    platform_power_monitor_low_a: assert property (cin[IN_BATTERY_ONLY] &&
        !cin[IN_BAT_ABOVE_5V2] |=> !platform_power_monitor_enable)
        else $error("power monitor on below 5.2V");
    wdt_off_a: assert property (wdt_expired |=> !battery_switch_gate)
        else $error("gate on after expiry");
    wdt_keep_a: assert property (wdt_hit |=>
        charge_current_setting == $past(charge_current_setting) || $past(kick))
        else $error("charge current lost at expiry");
    wdt_dis_a: assert property (primary_option_reg[WDT_DIS_BIT]
        |=> !wdt_expired)
        else $error("watchdog active while disabled");
endmodule : charger_mode_control
`default_nettype wire

// file: charger_mode_control_tb.sv
// self-checking bench of the charger mode control block
`timescale 1ns/10ps
`default_nettype none
module charger_mode_control_tb;
    import charger_mode_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_en, gate, ipl, vref, trk, fst, upr;
    logic men, msel, mdir, pen, pgl;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr = 8'h00;
    logic [15:0] wr_data, rd_data, lim, d;
    logic [1:0] tcode;
    logic [IN_COUNT-1:0] comp_raw = '0;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    always #4 clk = ~clk;
    charger_host_model i_charger_host_model (.clk(clk), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data));
    // long exit and watchdog periods 1..3 follow from the shortened bases
    charger_mode_control #(.EXIT_SHORT_CYC(20), .WDT0_CYC(50),
        .T1_CYC(10), .T2_CYC(5)) i_charger_mode_control (
        .clk(clk), .rst_b(rst_b), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
        .comp_raw(comp_raw), .battery_switch_gate(gate),
        .input_power_limit(ipl), .vin_ref_select(vref),
        .active_adapter_limit(lim), .trickle_charge(trk),
        .fast_charge(fst), .trickle_current_code(tcode),
        .regulate_upper_rail(upr), .monitor_enable(men),
        .monitor_battery_select(msel), .monitor_direction(mdir),
        .platform_power_monitor_enable(pen),
        .platform_power_gain_low(pgl));
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk_w(string nm, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_w
    task automatic chk_b(string nm, logic e, logic g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_b
    task automatic wt(int k);
        repeat (k) @(negedge clk);
    endtask : wt
    task automatic wr(logic [7:0] a, logic [15:0] v);
        i_charger_host_model.wr(a, v);
        wt(2);
    endtask : wr
    task automatic rdchk(string nm, logic [7:0] a, logic [15:0] e);
        @(negedge clk);
        rd_addr = a;
        @(negedge clk);
        chk_w(nm, e, rd_data);
    endtask : rdchk
    // comparator change plus sync and decode latency
    task automatic cmp(logic [IN_COUNT-1:0] v);
        @(negedge clk);
        comp_raw = v;
        wt(8);
    endtask : cmp
    // cycles the applied limit holds one code
    task automatic run(logic [15:0] v, output int k);
        k = 0;
        while (lim === v && k < 100) begin
            @(negedge clk);
            k++;
        end
    endtask : run
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk_b("gate", 1'b0, gate);
        chk_b("upper", 1'b1, upr);
        rdchk("status", MODE_STATUS_ADDR, 16'h0000);
        rdchk("unmapped", 8'h77, 16'h0000);
        wr(PRIMARY_OPTION_ADDR, 16'h0085);
        wr(MODE_STATUS_ADDR, 16'hFFFF);
        rdchk("primary", PRIMARY_OPTION_ADDR, 16'h0085);
        rdchk("status ro", MODE_STATUS_ADDR, 16'h0000);
        chk_b("vin ref", 1'b1, vref);
    endtask : t_reset
    task automatic t_limit_in();
        cmp(10'h1 << IN_VIN_AT_REF);
        chk_b("limit vin", 1'b1, ipl);
        cmp('0);
        chk_b("limit off", 1'b0, ipl);
        cmp(10'h1 << IN_ADP_AT_LIMIT);
        chk_b("limit adp", 1'b1, ipl);
    endtask : t_limit_in
    task automatic t_monitors();
        wr(SECONDARY_CONFIG_ADDR, 16'h0038);
        wr(QUATERNARY_OPTION_ADDR, 16'h0208);
        chk_b("mon en", 1'b1, men);
        chk_b("mon sel", 1'b1, msel);
        chk_b("mon dir", 1'b1, mdir);
        chk_b("gain", 1'b1, pgl);
        cmp((10'h1 << IN_BATTERY_ONLY) | (10'h1 << IN_BAT_ABOVE_5V2));
        chk_b("platform_power_monitor", 1'b1, pen);
        cmp(10'h1 << IN_BATTERY_ONLY);
        chk_b("platform_power_monitor low bat", 1'b0, pen);
        wr(SECONDARY_CONFIG_ADDR, 16'h0000);
        wr(QUATERNARY_OPTION_ADDR, 16'h0000);
        chk_b("mon off", 1'b0, men);
        chk_b("gain off", 1'b0, pgl);
    endtask : t_monitors
    task automatic t_charge();
        cmp((10'h1 << IN_BAT_PRESENT) | (10'h1 << IN_BAT_BELOW_MIN));
        chk_b("trickle zero", 1'b0, trk);
        wr(CHARGE_CURRENT_ADDR, 16'h0100);
        chk_b("gate chg", 1'b1, gate);
        chk_b("trickle", 1'b1, trk);
        chk_b("upper on", 1'b0, upr);
        for (int c = 0; c < 4; c++) begin
            wr(TERTIARY_CONFIG_ADDR, 16'(c) << TRICKLE_LSB);
            chk_w("tcode", 16'(c), 16'(tcode));
        end
        cmp(10'h1 << IN_BAT_PRESENT);
        chk_b("trickle end", 1'b0, trk);
        chk_b("fast", 1'b1, fst);
        wr(CHARGE_CURRENT_ADDR, 16'h0000);
        chk_b("gate zero", 1'b0, gate);
        chk_b("upper off", 1'b1, upr);
    endtask : t_charge
    task automatic t_turbo();
        cmp(10'h1 << IN_SYS_BELOW_BAT);
        chk_b("turbo off", 1'b0, gate);
        wr(PRIMARY_OPTION_ADDR, 16'h0080);
        for (int s = 0; s < 2; s++) begin
            wr(QUATERNARY_OPTION_ADDR, 16'(s) << EXIT_SEL_BIT);
            cmp(10'h1 << IN_SYS_BELOW_BAT);
            chk_b("turbo gate", 1'b1, gate);
            @(negedge clk);
            comp_raw = 10'h1 << IN_DSG_BELOW_200MA;
            n = 0;
            while (gate === 1'b1 && n < 200) begin
                @(negedge clk);
                n++;
            end
            chk_b("exit time", 1'b1, n >= 20 * (s + 1) &&
                n <= 20 * (s + 1) + 8);
        end
        cmp(10'h1 << IN_SYS_BELOW_BAT);
        cmp(10'h1 << IN_CHG_150MA);
        chk_b("exit chg", 1'b0, gate);
    endtask : t_turbo
    task automatic t_two_level();
        wr(ADAPTER_FIRST_ADDR, 16'h0300);
        wr(ADAPTER_SECOND_ADDR, 16'h0100);
        wr(TERTIARY_CONFIG_ADDR, 16'h0000);
        cmp(10'h1 << IN_ADP_NEAR_FIRST);
        run(16'h0300, n);
        chk_w("first only", 16'd100, 16'(n));
        wr(TERTIARY_CONFIG_ADDR, 16'h1000);
        n = 0;
        while (lim !== 16'h0100 && n < 50) begin
            @(negedge clk);
            n++;
        end
        run(16'h0100, n);
        chk_w("t2", 16'd5, 16'(n));
        run(16'h0300, n);
        chk_w("t1", 16'd10, 16'(n));
        run(16'h0100, n);
        chk_w("t2 again", 16'd5, 16'(n));
        cmp('0);
        chk_w("idle", 16'h0300, lim);
    endtask : t_two_level
    task automatic t_watchdog();
        wr(CHARGE_CURRENT_ADDR, 16'h0040);
        cmp(10'h1 << IN_BAT_PRESENT);
        wr(PRIMARY_OPTION_ADDR, 16'h0001);
        i_charger_host_model.kick(16'h1000);
        wt(40);
        i_charger_host_model.kick(16'h1000);
        wt(40);
        chk_b("kept", 1'b1, gate);
        wt(30);
        chk_b("expired", 1'b0, gate);
        rdchk("cc kept", CHARGE_CURRENT_ADDR, 16'h0040);
        @(negedge clk);
        rd_addr = MODE_STATUS_ADDR;
        wt(1);
        chk_b("exp flag", 1'b1, rd_data[1]);
        wr(QUATERNARY_OPTION_ADDR, 16'h0800);
        i_charger_host_model.kick(16'h1000);
        wt(2);
        chk_b("resumed", 1'b1, gate);
        wt(80);
        chk_b("long kept", 1'b1, gate);
        wt(40);
        chk_b("long exp", 1'b0, gate);
        wr(PRIMARY_OPTION_ADDR, 16'h0081);
        wr(CHARGE_CURRENT_ADDR, 16'h0040);
        wt(250);
        chk_b("wdt off", 1'b1, gate);
    endtask : t_watchdog
    ////////////////////////////////////////////////////////////////////
    // hang guard well above the thousand or so cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        wt(20);
        rst_b = 1'b1;
        wt(1);
        t_reset();
        t_limit_in();
        t_monitors();
        t_charge();
        t_turbo();
        t_two_level();
        t_watchdog();
        end_of_test();
    end
endmodule : charger_mode_control_tb
`default_nettype wire

// file: charger_mode_pkg.sv
// shared constants of the charger mode control block
package charger_mode_pkg;
    // register command codes
    localparam logic [7:0] PRIMARY_OPTION_ADDR = 8'h39;
    localparam logic [7:0] SECONDARY_CONFIG_ADDR = 8'h3C;
    localparam logic [7:0] TERTIARY_CONFIG_ADDR = 8'h3D;
    localparam logic [7:0] QUATERNARY_OPTION_ADDR = 8'h4C;
    localparam logic [7:0] CHARGE_CURRENT_ADDR = 8'h14;
    localparam logic [7:0] UPPER_RAIL_ADDR = 8'h15;
    localparam logic [7:0] ADAPTER_FIRST_ADDR = 8'h3F;
    localparam logic [7:0] ADAPTER_SECOND_ADDR = 8'h3B;
    localparam logic [7:0] MODE_STATUS_ADDR = 8'h50;
    // reset values
    localparam logic [15:0] OPTION_RESET = 16'h0000;
    localparam logic [15:0] SETTING_RESET = 16'h0000;
    // field positions
    localparam int TURBO_DIS_BIT = 0;
    localparam int VIN_REF_BIT = 2;
    localparam int WDT_DIS_BIT = 7;
    localparam int PLATFORM_POWER_MONITOR_EN_BIT = 3;
    localparam int MON_SEL_BIT = 4;
    localparam int MON_EN_BIT = 5;
    localparam int TWO_LEVEL_BIT = 12;
    localparam int TRICKLE_LSB = 14;
    localparam int MON_DIR_BIT = 3;
    localparam int EXIT_SEL_BIT = 8;
    localparam int PLATFORM_POWER_MONITOR_GAIN_BIT = 9;
    localparam int WDT_SEL_LSB = 11;
    // timing, in printed units
    localparam longint CLK_HZ = 125_000_000;
    localparam longint TURBO_EXIT_SHORT_MS = 40;
    localparam longint TURBO_EXIT_LONG_MS = 80;
    localparam longint WDT_BASE_S = 175;
    localparam longint TURBO_EXIT_SHORT_CYC = TURBO_EXIT_SHORT_MS * CLK_HZ / 1000;
    localparam longint TURBO_EXIT_LONG_CYC = TURBO_EXIT_LONG_MS * CLK_HZ / 1000;
    localparam longint WDT_BASE_CYC = WDT_BASE_S * CLK_HZ;
    // comparator input positions
    localparam int IN_ADP_AT_LIMIT = 0;
    localparam int IN_VIN_AT_REF = 1;
    localparam int IN_SYS_BELOW_BAT = 2;
    localparam int IN_CHG_150MA = 3;
    localparam int IN_DSG_BELOW_200MA = 4;
    localparam int IN_ADP_NEAR_FIRST = 5;
    localparam int IN_BAT_BELOW_MIN = 6;
    localparam int IN_BAT_PRESENT = 7;
    localparam int IN_BAT_ABOVE_5V2 = 8;
    localparam int IN_BATTERY_ONLY = 9;
    localparam int IN_COUNT = 10;
    // two-level limiter phases, gray along idle, second, first
    typedef enum logic [1:0] {
        LIM_IDLE = 2'b00,
        LIM_SECOND = 2'b01,
        LIM_FIRST = 2'b11
    } limit_phase_t;
endpackage : charger_mode_pkg
